// ===== hemb_defs.vh
`ifndef HEMB_DEFS_VH
`define HEMB_DEFS_VH

// =============================================================
// bus regions (word per register, byte address = index * 4)
`define HEMB_HOST_REGION 24'h000F00
`define HEMB_CTRL_REGION 24'h000F01

// =============================================================
// host view register indexes
`define HEMB_H_H2C_MBOX 6'h00
`define HEMB_H_C2H_MBOX 6'h01
`define HEMB_H_SRC_LSB 6'h08
`define HEMB_H_SRC_MSB 6'h09
`define HEMB_H_EN_LSB 6'h0A
`define HEMB_H_EN_MSB 6'h0B
`define HEMB_H_CLAIM 6'h0C

// =============================================================
// controller-only bank indexes
`define HEMB_C_H2C_MBOX 6'h00
`define HEMB_C_C2H_MBOX 6'h01
`define HEMB_C_BASE0 6'h04
`define HEMB_C_RLIM0 6'h08
`define HEMB_C_WLIM0 6'h0A
`define HEMB_C_BASE1 6'h0C
`define HEMB_C_RLIM1 6'h10
`define HEMB_C_WLIM1 6'h12
`define HEMB_C_INT_SET 6'h14
`define HEMB_C_CLR_EN 6'h16
`define HEMB_C_IRQ_STAT 6'h18
`define HEMB_C_IRQ_CLR 6'h19
`define HEMB_C_IRQ_EN 6'h1A

// =============================================================
// field positions and reset values
`define HEMB_FLAG_BIT 0
`define HEMB_IRQ_MBOX_BIT 0
`define HEMB_IRQ_CLAIM_BIT 1
`define HEMB_BYTE_RST 8'h00
`define HEMB_HALF_RST 16'h0000
`define HEMB_WORD_RST 32'h00000000

`endif

// ===== hemb_mailbox.v
// Chosen here: register access over AHB-Lite.
`include "hemb_defs.vh"

module hemb_mailbox (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   // events
   output reg host_software_event,
   output reg ctrl_irq
);

   // =============================================================
   // address phase capture
   reg wr_pend_q;
   reg rd_pend_q;
   reg a_host_q;
   reg a_ctrl_q;
   reg [5:0] a_idx_q;
   wire take = hsel & hready & htrans[1] & (hsize == 3'b010) & (haddr[1:0] == 2'b00);
   wire in_host = (haddr[31:8] == `HEMB_HOST_REGION);
   wire in_ctrl = (haddr[31:8] == `HEMB_CTRL_REGION);

   // =============================================================
   // registers
   reg [7:0] mbox_h2c_q;
   reg [7:0] mbox_c2h_q;
   reg [15:0] src_q;
   reg [15:0] en_q;
   reg [7:0] claim_q;
   reg [31:2] base0_q;
   reg [14:2] rlim0_q;
   reg [14:2] wlim0_q;
   reg [31:2] base1_q;
   reg [14:2] rlim1_q;
   reg [14:2] wlim1_q;
   reg [15:0] clr_en_q;
   reg [1:0] irq_stat_q;
   reg [1:0] irq_en_q;

   wire hw = wr_pend_q & a_host_q;
   wire cw = wr_pend_q & a_ctrl_q;
   wire [7:0] wb = hwdata[7:0];

   // =============================================================
   // next enables, so an event follows an enable write at the same edge
   reg [15:0] en_d;
   reg [1:0] irq_en_d;
   always @* begin
      en_d = en_q;
      irq_en_d = irq_en_q;
      if (hw && a_idx_q == `HEMB_H_EN_LSB)
         en_d[7:0] = wb;
      if (hw && a_idx_q == `HEMB_H_EN_MSB)
         en_d[15:8] = wb;
      if (cw && a_idx_q == `HEMB_C_IRQ_EN)
         irq_en_d = hwdata[1:0];
   end
   wire hr_c2h = rd_pend_q & a_host_q & (a_idx_q == `HEMB_H_C2H_MBOX) & ~hreadyout;

   // =============================================================
   // bus handshake: writes finish with no wait, reads take one wait
   // state so the read sees any write that just completed
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         a_host_q <= 1'b0;
         a_ctrl_q <= 1'b0;
         a_idx_q <= 6'h00;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         if (hreadyout) begin
            wr_pend_q <= take & hwrite;
            rd_pend_q <= take & ~hwrite;
            a_host_q <= in_host;
            a_ctrl_q <= in_ctrl;
            a_idx_q <= haddr[7:2];
            hreadyout <= ~(take & ~hwrite);
         end else begin
            rd_pend_q <= 1'b0;
            hreadyout <= 1'b1;
         end
      end
   end

   // =============================================================
   // mailboxes, claim, window registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mbox_h2c_q <= `HEMB_BYTE_RST;
         mbox_c2h_q <= `HEMB_BYTE_RST;
         claim_q <= `HEMB_BYTE_RST;
         en_q <= `HEMB_HALF_RST;
         clr_en_q <= `HEMB_HALF_RST;
         base0_q <= 30'h00000000;
         base1_q <= 30'h00000000;
         rlim0_q <= 13'h0000;
         wlim0_q <= 13'h0000;
         rlim1_q <= 13'h0000;
         wlim1_q <= 13'h0000;
      end else begin
         // one storage byte serves both views
         if (hw && a_idx_q == `HEMB_H_H2C_MBOX)
            mbox_h2c_q <= wb;
         else if (cw && a_idx_q == `HEMB_C_H2C_MBOX)
            mbox_h2c_q <= mbox_h2c_q & ~wb;
         if (cw && a_idx_q == `HEMB_C_C2H_MBOX)
            mbox_c2h_q <= wb;
         if (hw && a_idx_q == `HEMB_H_CLAIM) begin
            if (claim_q == 8'h00)
               claim_q <= wb;
            else if (wb == claim_q)
               claim_q <= 8'h00;
            // any other value leaves the claim alone
         end
         en_q <= en_d;
         if (cw) begin
            case (a_idx_q)
               `HEMB_C_BASE0: base0_q <= hwdata[31:2];
               `HEMB_C_RLIM0: rlim0_q <= hwdata[14:2];
               `HEMB_C_WLIM0: wlim0_q <= hwdata[14:2];
               `HEMB_C_BASE1: base1_q <= hwdata[31:2];
               `HEMB_C_RLIM1: rlim1_q <= hwdata[14:2];
               `HEMB_C_WLIM1: wlim1_q <= hwdata[14:2];
               `HEMB_C_CLR_EN: clr_en_q <= {hwdata[15:1], 1'b0};
               default: ;
            endcase
         end
      end
   end

   // =============================================================
   // software interrupt sources; bit 0 is the mailbox-written flag,
   // cleared when the host reads the outgoing mailbox
   reg [15:0] src_d;
   always @* begin
      src_d = src_q;
      if (hr_c2h)
         src_d[`HEMB_FLAG_BIT] = 1'b0;
      if (hw && a_idx_q == `HEMB_H_SRC_LSB)
         src_d[7:1] = src_q[7:1] & ~(wb[7:1] & clr_en_q[7:1]);
      if (hw && a_idx_q == `HEMB_H_SRC_MSB)
         src_d[15:8] = src_q[15:8] & ~(wb & clr_en_q[15:8]);
      if (cw && a_idx_q == `HEMB_C_INT_SET)
         src_d[15:1] = src_q[15:1] | hwdata[15:1];
      // set beats a clear landing in the same cycle
      if (cw && a_idx_q == `HEMB_C_C2H_MBOX)
         src_d[`HEMB_FLAG_BIT] = 1'b1;
   end

   // =============================================================
   // controller interrupt status, enable and write-one clear
   wire claim_evt = hw & (a_idx_q == `HEMB_H_CLAIM) & ((claim_q == 8'h00) | (wb == claim_q));
   wire [1:0] irq_set = {claim_evt, hw & (a_idx_q == `HEMB_H_H2C_MBOX)};
   wire [1:0] irq_clr = (cw && a_idx_q == `HEMB_C_IRQ_CLR) ? hwdata[1:0] : 2'b00;
   wire [1:0] irq_stat_d = irq_set | (irq_stat_q & ~irq_clr);

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         src_q <= `HEMB_HALF_RST;
         irq_stat_q <= 2'b00;
         irq_en_q <= 2'b00;
         host_software_event <= 1'b0;
         ctrl_irq <= 1'b0;
      end else begin
         src_q <= src_d;
         irq_stat_q <= irq_stat_d;
         irq_en_q <= irq_en_d;
         host_software_event <= |(src_d & en_d);
         ctrl_irq <= |(irq_stat_d & irq_en_d);
      end
   end

   // =============================================================
   // read data, loaded during the wait state
   reg [31:0] rd_d;
   always @* begin
      rd_d = `HEMB_WORD_RST;
      if (a_host_q) begin
         case (a_idx_q)
            `HEMB_H_H2C_MBOX: rd_d = {24'h000000, mbox_h2c_q};
            `HEMB_H_C2H_MBOX: rd_d = {24'h000000, mbox_c2h_q};
            `HEMB_H_SRC_LSB: rd_d = {24'h000000, src_q[7:0]};
            `HEMB_H_SRC_MSB: rd_d = {24'h000000, src_q[15:8]};
            `HEMB_H_EN_LSB: rd_d = {24'h000000, en_q[7:0]};
            `HEMB_H_EN_MSB: rd_d = {24'h000000, en_q[15:8]};
            `HEMB_H_CLAIM: rd_d = {24'h000000, claim_q};
            default: rd_d = `HEMB_WORD_RST;
         endcase
      end else if (a_ctrl_q) begin
         case (a_idx_q)
            `HEMB_C_H2C_MBOX: rd_d = {24'h000000, mbox_h2c_q};
            `HEMB_C_C2H_MBOX: rd_d = {24'h000000, mbox_c2h_q};
            `HEMB_C_BASE0: rd_d = {base0_q, 2'b00};
            `HEMB_C_RLIM0: rd_d = {17'h00000, rlim0_q, 2'b00};
            `HEMB_C_WLIM0: rd_d = {17'h00000, wlim0_q, 2'b00};
            `HEMB_C_BASE1: rd_d = {base1_q, 2'b00};
            `HEMB_C_RLIM1: rd_d = {17'h00000, rlim1_q, 2'b00};
            `HEMB_C_WLIM1: rd_d = {17'h00000, wlim1_q, 2'b00};
            `HEMB_C_INT_SET: rd_d = {16'h0000, src_q};
            `HEMB_C_CLR_EN: rd_d = {16'h0000, clr_en_q};
            `HEMB_C_IRQ_STAT: rd_d = {30'h00000000, irq_stat_q};
            `HEMB_C_IRQ_EN: rd_d = {30'h00000000, irq_en_q};
            default: rd_d = `HEMB_WORD_RST;
         endcase
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn)
         hrdata <= `HEMB_WORD_RST;
      else if (rd_pend_q && !hreadyout)
         hrdata <= rd_d;
   end

endmodule

// ===== hemb_mailbox_assertions.sv
// ==========================================
// bus timing and event cause checks
module hemb_mailbox_chk (
   // clock and reset
   input wire hclk,
   input wire hresetn,
   // ahb-lite
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire hready,
   input wire [31:0] hrdata,
   input wire hreadyout,
   // events
   input wire host_software_event,
   input wire ctrl_irq
);
   wire tk = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[1:0] == 2'h0;
   reg wd_q, rd_q, bad_q;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wd_q <= 1'h0;
         rd_q <= 1'h0;
         bad_q <= 1'h0;
      end else begin
         wd_q <= tk && hwrite;
         rd_q <= tk && !hwrite;
         bad_q <= haddr[31:9] != 23'h000780;
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   property p_rdw; tk && !hwrite |=> s_wait; endproperty
   property p_wrw; tk && hwrite |=> hreadyout; endproperty
   property p_low; !hreadyout |-> $past(tk && !hwrite); endproperty
   property p_hold; !$stable(hrdata) |-> $rose(hreadyout); endproperty
   property p_unmap; rd_q && bad_q |=> hrdata == 32'h0; endproperty
   property p_evup; $rose(host_software_event) |-> $past(wd_q); endproperty
   property p_evdn; $fell(host_software_event) |-> $past(wd_q || rd_q); endproperty
   property p_irq; $rose(ctrl_irq) |-> $past(wd_q); endproperty
   a_rdw: assert property (p_rdw) else $error("read wait state wrong");
   a_wrw: assert property (p_wrw) else $error("write stalled");
   a_low: assert property (p_low) else $error("stray wait state");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   a_evup: assert property (p_evup) else $error("host event rose unprompted");
   a_evdn: assert property (p_evdn) else $error("host event fell unprompted");
   a_irq: assert property (p_irq) else $error("controller irq rose unprompted");
endmodule

bind hemb_mailbox hemb_mailbox_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
   .host_software_event(host_software_event), .ctrl_irq(ctrl_irq));

// ===== hemb_host_bfm.sv
// ==========================================
// host side bus master
module hemb_host_bfm (
   // clock
   input wire hclk,
   // ahb-lite master
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire hready,
   input wire [31:0] hrdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (!hready) @(posedge hclk);
      q = hrdata;
      // released data lines must not keep looking valid
      hwdata <= ~d;
   endtask
endmodule

// ===== test_host_ec_mailbox_and_app_claim.sv
`include "hemb_defs.vh"
// ==========================================
// self-checking bench
module test_host_ec_mailbox_and_app_claim;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [23:0] H = `HEMB_HOST_REGION;
   localparam logic [23:0] C = `HEMB_CTRL_REGION;
   logic hclk, hresetn, hwrite, hready, hresp, host_software_event, ctrl_irq;
   logic [31:0] haddr, hwdata, hrdata, rd_v, seed;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] v, e, w, cl;
   logic [5:0] ix [7] = '{`HEMB_C_BASE0, `HEMB_C_RLIM0, `HEMB_C_WLIM0, `HEMB_C_BASE1, `HEMB_C_RLIM1,
      `HEMB_C_WLIM1, `HEMB_C_CLR_EN};
   logic [31:0] mk [7] = '{32'hFFFFFFFC, 32'h7FFC, 32'h7FFC, 32'hFFFFFFFC, 32'h7FFC, 32'h7FFC, 32'hFFFE};
   int fail_count = 0;
   int checks_done = 0;
   hemb_mailbox dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .host_software_event(host_software_event), .ctrl_irq(ctrl_irq));
   hemb_host_bfm host_u (.hclk(hclk), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hrdata(hrdata));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [7:0] claim_next(input logic [7:0] h, input logic [7:0] d);
      claim_next = (h == 8'h0) ? d : ((d == h) ? 8'h0 : h);
   endfunction
   task wr(input logic [23:0] r, input logic [5:0] i, input logic [31:0] d);
      host_u.xfer(1'h1, {r, i, 2'h0}, d, rd_v);
   endtask
   task chk(input logic [23:0] r, input logic [5:0] i, input logic [31:0] x);
      host_u.xfer(1'h0, {r, i, 2'h0}, 32'h0, rd_v);
      checks_done++;
      if (rd_v !== x) begin
         fail_count++;
         $display("BAD %0t read %h want %h", $time, rd_v, x);
      end
      checks_done++;
      if (hresp !== 1'h0) begin
         fail_count++;
         $display("BAD %0t response not okay", $time);
      end
   endtask
   task ev(input logic h, input logic c);
      @(negedge hclk);
      checks_done++;
      if ({host_software_event, ctrl_irq} !== {h, c}) begin
         fail_count++;
         $display("BAD %0t events %b%b", $time, host_software_event, ctrl_irq);
      end
   endtask
   task stop_test();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'h0;
      forever #25 hclk = ~hclk;
   end
   initial begin
      #2000000;
      fail_count++;
      stop_test();
   end
   initial begin
      hresetn = 1'h0;
      seed = 32'h2758;
      cl = 8'h0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'h1;
      chk(H, `HEMB_H_CLAIM, 32'h0);
      chk(H, `HEMB_H_EN_MSB, 32'h0);
      // every third write repeats the held value, so claims get released
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         w = (k % 3 == 0) ? cl : seed[7:0];
         wr(H, `HEMB_H_CLAIM, {24'h0, w});
         cl = claim_next(cl, w);
         chk(H, `HEMB_H_CLAIM, {24'h0, cl});
      end
      wr(C, `HEMB_C_IRQ_CLR, 32'h3);
      wr(C, `HEMB_C_IRQ_EN, 32'h0);
      wr(H, `HEMB_H_H2C_MBOX, {24'h0, seed[15:8]});
      ev(1'h0, 1'h0);
      wr(C, `HEMB_C_IRQ_EN, 32'h1);
      ev(1'h0, 1'h1);
      chk(C, `HEMB_C_H2C_MBOX, {24'h0, seed[15:8]});
      wr(C, `HEMB_C_H2C_MBOX, {24'h0, seed[23:16]});
      chk(H, `HEMB_H_H2C_MBOX, {24'h0, seed[15:8] & ~seed[23:16]});
      wr(C, `HEMB_C_IRQ_CLR, 32'h3);
      ev(1'h0, 1'h0);
      for (int k = 0; k < 4; k++) begin
         seed = lfsr(seed);
         v = seed[7:0] | 8'h01;
         e = (k == 0) ? ~v : seed[15:8];
         wr(C, `HEMB_C_INT_SET, {16'h0, v, 8'h0});
         wr(H, `HEMB_H_EN_MSB, {24'h0, e});
         ev(|(v & e), 1'h0);
         wr(C, `HEMB_C_CLR_EN, 32'h0);
         wr(H, `HEMB_H_SRC_MSB, 32'hFF);
         chk(H, `HEMB_H_SRC_MSB, {24'h0, v});
         wr(C, `HEMB_C_CLR_EN, 32'hFF00);
         wr(H, `HEMB_H_SRC_MSB, {24'h0, v});
         ev(1'h0, 1'h0);
      end
      wr(H, `HEMB_H_EN_LSB, 32'h1);
      wr(C, `HEMB_C_C2H_MBOX, 32'h5A);
      ev(1'h1, 1'h0);
      chk(H, `HEMB_H_C2H_MBOX, 32'h5A);
      ev(1'h0, 1'h0);
      foreach (ix[j]) begin
         seed = lfsr(seed);
         wr(C, ix[j], seed);
         chk(C, ix[j], seed & mk[j]);
      end
      wr(H, 6'h02, seed);
      chk(H, 6'h02, 32'h0);
      chk(24'h000F02, 6'h00, 32'h0);
      stop_test();
   end
endmodule
